// file: verilog/sumt_map.svh
/*
 * Constant map of the SPI message bridge: command bytes, status bit
 * positions, reset values and sizes.
 * Assumes inclusion by bare name from the bridge's design files.
 */
`ifndef SUMT_MAP_SVH
`define SUMT_MAP_SVH

// SPI command bytes
`define SUMT_CMD_LOAD_QUEUE      8'hc0
`define SUMT_CMD_NEXT_QUEUE      8'hb0
`define SUMT_CMD_READ_STATUS     8'h01
`define SUMT_CMD_READ_NEXT_MSG   8'h93
`define SUMT_CMD_BROADCAST_WRITE 8'h02

// Receive status bit positions
`define SUMT_STAT_STOP_BIT       1
`define SUMT_STAT_RX_ERR_BIT     2
`define SUMT_STAT_OVERFLOW_BIT   3

// Reset values and sizes
`define SUMT_BYTE_RST            8'h00
`define SUMT_CRC_INIT            8'h00
`define SUMT_CRC_POLY            8'ha6
`define SUMT_FIFO_DEPTH          16
`define SUMT_FIFO_AW             4

`endif

// file: verilog/sumt_pkg.sv
/*
 * Types of the SPI message bridge: command decoder states and the
 * phases of a receive buffer read.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package sumt_pkg;

    typedef enum logic [2:0] {
        ST_CMD,
        ST_LEN,
        ST_LOAD,
        ST_STAT,
        ST_READ,
        ST_IGNORE
    } sumt_state_t;

    typedef enum logic [1:0] {
        PH_DATA,
        PH_LOCKSTEP,
        PH_CHECK,
        PH_DONE
    } sumt_phase_t;

endpackage : sumt_pkg

`default_nettype wire

// file: verilog/sumt_fifo.sv
/*
 * Byte FIFO with valid/ready on both sides and a registered output stage.
 * Assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sumt_map.svh"

module sumt_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = `SUMT_FIFO_DEPTH,
    parameter int AW    = `SUMT_FIFO_AW
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         reset,
    // Fill side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output var  logic         in_ready,
    // Drain side
    output var  logic         out_valid,
    output var  logic [W-1:0] out_data,
    input  wire logic         out_ready,
    // Flush, drops all content
    input  wire logic         flush
);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
    logic [AW:0]   count_ff, nxt_count;
    logic          in_ready_ff, nxt_in_ready;
    logic          out_valid_ff, nxt_out_valid;
    logic [W-1:0]  out_data_ff, nxt_out_data;
    logic          push, pop;

    assign in_ready  = in_ready_ff;
    assign out_valid = out_valid_ff;
    assign out_data  = out_data_ff;

    // Pointers, count and output stage; storage count excludes output stage
    always_comb begin
        push          = in_valid && in_ready_ff;
        pop           = (count_ff != '0) && (!out_valid_ff || out_ready);
        nxt_wr_ptr    = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
        nxt_rd_ptr    = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
        nxt_count     = count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        nxt_out_valid = pop ? 1'b1 : (out_ready ? 1'b0 : out_valid_ff);
        nxt_out_data  = pop ? mem[rd_ptr_ff] : out_data_ff;
        if (flush) begin
            nxt_wr_ptr    = '0;
            nxt_rd_ptr    = '0;
            nxt_count     = '0;
            nxt_out_valid = 1'b0;
        end
        // Room counts the output stage too, so DEPTH words in all
        nxt_in_ready  = (nxt_count + (AW+1)'(nxt_out_valid)) < (AW+1)'(DEPTH);
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wr_ptr_ff    <= '0;
            rd_ptr_ff    <= '0;
            count_ff     <= '0;
            in_ready_ff  <= 1'b0;
            out_valid_ff <= 1'b0;
            out_data_ff  <= '0;
        end else begin
            wr_ptr_ff    <= nxt_wr_ptr;
            rd_ptr_ff    <= nxt_rd_ptr;
            count_ff     <= nxt_count;
            in_ready_ff  <= nxt_in_ready;
            out_valid_ff <= nxt_out_valid;
            out_data_ff  <= nxt_out_data;
        end
    end

    // Storage; no reset needed, guarded by count
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

endmodule : sumt_fifo

`default_nettype wire

// file: verilog/sumt_bridge.sv
/*
 * SPI slave message path of an SPI to UART chain bridge: queue load and
 * launch, receive status and receive buffer read with appended bytes.
 * Assumes SPI mode 0 from the host and a same-clock UART byte engine.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sumt_map.svh"

module sumt_bridge #(
    parameter int        DEPTH    = `SUMT_FIFO_DEPTH,
    parameter int        AW       = `SUMT_FIFO_AW,
    parameter logic [7:0] CRC_POLY = `SUMT_CRC_POLY
) (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // SPI pins from host
    input  wire logic       spi_sclk,
    input  wire logic       spi_cs_n,
    input  wire logic       spi_mosi,
    output var  logic       spi_miso,
    // Byte stream to UART transmitter
    output var  logic       utx_valid,
    output var  logic [7:0] utx_data,
    input  wire logic       utx_ready,
    // Byte stream from UART receiver
    input  wire logic       urx_valid,
    input  wire logic [7:0] urx_data,
    input  wire logic       urx_stop,
    input  wire logic       urx_char_err,
    // Lockstep monitor state
    input  wire logic [7:0] lockstep_status_byte,
    // Status
    output var  logic       load_overflow,
    output var  logic       sending
);

    // Pin synchronisers, three taps on clock for edge finding
    logic [2:0] sclk_sync_ff;
    logic [1:0] cs_n_sync_ff, mosi_sync_ff;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sclk_sync_ff <= 3'h0;
            cs_n_sync_ff <= 2'h3;
            mosi_sync_ff <= 2'h0;
        end else begin
            sclk_sync_ff <= {sclk_sync_ff[1:0], spi_sclk};
            cs_n_sync_ff <= {cs_n_sync_ff[0], spi_cs_n};
            mosi_sync_ff <= {mosi_sync_ff[0], spi_mosi};
        end
    end

    logic sclk_rise, sclk_fall, cs_idle;
    assign sclk_rise = sclk_sync_ff[1] && !sclk_sync_ff[2];
    assign sclk_fall = !sclk_sync_ff[1] && sclk_sync_ff[2];
    assign cs_idle   = cs_n_sync_ff[1];

    // CRC-8, MSB first; covers every byte shifted out ahead of it
    function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] din);
        logic [7:0] c;
        c = crc ^ din;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction : crc8_byte

    sumt_pkg::sumt_state_t state_ff, nxt_state;
    sumt_pkg::sumt_phase_t phase_ff, nxt_phase;
    logic [2:0] bit_cnt_ff, nxt_bit_cnt;
    logic [7:0] rx_sr_ff, nxt_rx_sr, tx_sr_ff, nxt_tx_sr;
    logic       miso_ff, nxt_miso;
    logic [7:0] load_left_ff, nxt_load_left, q_len_ff, nxt_q_len;
    logic [7:0] send_left_ff, nxt_send_left, crc_ff, nxt_crc;
    logic [7:0] msg_len_ff, nxt_msg_len, arrive_cnt_ff, nxt_arrive_cnt;
    logic [7:0] rd_left_ff, nxt_rd_left;
    logic       stop_ff, nxt_stop, rx_err_ff, nxt_rx_err, ovf_ff, nxt_ovf;
    logic       sending_ff, nxt_sending, ldovf_ff, nxt_ldovf;
    logic       utx_valid_ff, nxt_utx_valid;
    logic [7:0] utx_data_ff, nxt_utx_data;
    logic       byte_done;
    logic [7:0] byte_in, nxt_byte_out;
    logic       load_out;

    // FIFO hookups
    logic       txq_in_valid, txq_in_ready, txq_out_valid, txq_out_ready;
    logic [7:0] txq_out_data;
    logic       rxb_in_ready, rxb_out_valid, rxb_out_ready, rxb_flush;
    logic [7:0] rxb_out_data;

    sumt_fifo #(.W(8), .DEPTH(DEPTH), .AW(AW)) u_txq (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .in_valid (txq_in_valid),
        .in_data  (byte_in),
        .in_ready (txq_in_ready),
        .out_valid(txq_out_valid),
        .out_data (txq_out_data),
        .out_ready(txq_out_ready),
        .flush    (1'b0)
    );

    sumt_fifo #(.W(8), .DEPTH(DEPTH), .AW(AW)) u_rxb (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .in_valid (urx_valid),
        .in_data  (urx_data),
        .in_ready (rxb_in_ready),
        .out_valid(rxb_out_valid),
        .out_data (rxb_out_data),
        .out_ready(rxb_out_ready),
        .flush    (rxb_flush)
    );

    // Command decoding, SPI shifting, queue and buffer control
    always_comb begin
        nxt_state      = state_ff;
        nxt_phase      = phase_ff;
        nxt_bit_cnt    = bit_cnt_ff;
        nxt_rx_sr      = rx_sr_ff;
        nxt_tx_sr      = tx_sr_ff;
        nxt_miso       = miso_ff;
        nxt_load_left  = load_left_ff;
        nxt_q_len      = q_len_ff;
        nxt_send_left  = send_left_ff;
        nxt_crc        = crc_ff;
        nxt_msg_len    = msg_len_ff;
        nxt_arrive_cnt = arrive_cnt_ff;
        nxt_rd_left    = rd_left_ff;
        nxt_stop       = stop_ff;
        nxt_rx_err     = rx_err_ff;
        nxt_ovf        = ovf_ff;
        nxt_sending    = sending_ff;
        nxt_ldovf      = ldovf_ff;
        nxt_utx_valid  = utx_valid_ff;
        nxt_utx_data   = utx_data_ff;
        nxt_byte_out   = `SUMT_BYTE_RST;
        load_out       = 1'b0;
        txq_in_valid   = 1'b0;
        rxb_out_ready  = 1'b0;
        rxb_flush      = 1'b0;
        byte_in        = {rx_sr_ff[6:0], mosi_sync_ff[1]};
        byte_done      = !cs_idle && sclk_rise && (bit_cnt_ff == 3'h7);

        // Mode 0: sample on rise, present next bit on fall
        if (cs_idle) begin
            nxt_bit_cnt = 3'h0;
            nxt_state   = sumt_pkg::ST_CMD;
        end else if (sclk_rise) begin
            nxt_rx_sr   = byte_in;
            nxt_bit_cnt = bit_cnt_ff + 3'h1;
        end else if (sclk_fall) begin
            nxt_miso  = tx_sr_ff[7];
            nxt_tx_sr = {tx_sr_ff[6:0], 1'b0};
        end

        // Chain bytes into receive buffer; counted only when stored
        if (urx_valid && rxb_in_ready) begin
            nxt_arrive_cnt = arrive_cnt_ff + 8'h1;
        end

        if (byte_done) begin
            case (state_ff)
                sumt_pkg::ST_CMD: begin
                    nxt_state = sumt_pkg::ST_IGNORE;
                    if (byte_in == `SUMT_CMD_LOAD_QUEUE) begin
                        nxt_state = sumt_pkg::ST_LEN;
                        nxt_q_len = 8'h00;
                    end else if (byte_in == `SUMT_CMD_NEXT_QUEUE) begin
                        if (!sending_ff && q_len_ff != 8'h00) begin
                            nxt_sending   = 1'b1;
                            nxt_send_left = q_len_ff;
                            nxt_q_len     = 8'h00;
                        end
                    end else if (byte_in == `SUMT_CMD_READ_STATUS) begin
                        nxt_state = sumt_pkg::ST_STAT;
                        nxt_byte_out[`SUMT_STAT_STOP_BIT]     = stop_ff;
                        nxt_byte_out[`SUMT_STAT_RX_ERR_BIT]   = rx_err_ff;
                        nxt_byte_out[`SUMT_STAT_OVERFLOW_BIT] = ovf_ff;
                        nxt_rx_err = 1'b0;
                        nxt_ovf    = 1'b0;
                        load_out   = 1'b1;
                    end else if (byte_in == `SUMT_CMD_READ_NEXT_MSG) begin
                        nxt_state   = sumt_pkg::ST_READ;
                        nxt_phase   = sumt_pkg::PH_DATA;
                        nxt_crc     = `SUMT_CRC_INIT;
                        nxt_rd_left = msg_len_ff;
                        nxt_msg_len = 8'h00;
                        nxt_stop    = 1'b0;
                    end
                end
                sumt_pkg::ST_LEN: begin
                    nxt_load_left = byte_in;
                    nxt_state = (byte_in == 8'h00) ? sumt_pkg::ST_IGNORE : sumt_pkg::ST_LOAD;
                end
                sumt_pkg::ST_LOAD: begin
                    // store message byte; full queue or an active send drops it
                    if (txq_in_ready && !sending_ff) begin
                        txq_in_valid = 1'b1;
                        nxt_q_len    = q_len_ff + 8'h1;
                    end else begin
                        nxt_ldovf = 1'b1;
                    end
                    nxt_load_left = load_left_ff - 8'h1;
                    if (load_left_ff == 8'h01) begin
                        nxt_state = sumt_pkg::ST_IGNORE;
                    end
                end
                default: begin
                    nxt_state = state_ff;
                end
            endcase
        end

        // next read byte: echoed data first
        if (byte_done && state_ff == sumt_pkg::ST_READ || nxt_state == sumt_pkg::ST_READ
            && state_ff != sumt_pkg::ST_READ) begin
            load_out = 1'b1;
            // Next values, so the first byte sees the freshly started read
            case (nxt_phase)
                sumt_pkg::PH_DATA: begin
                    if (nxt_rd_left != 8'h00 && rxb_out_valid) begin
                        nxt_byte_out  = rxb_out_data;
                        rxb_out_ready = 1'b1;
                        nxt_rd_left   = nxt_rd_left - 8'h1;
                        nxt_crc       = crc8_byte(nxt_crc, rxb_out_data);
                    end else begin
                        nxt_byte_out = lockstep_status_byte;
                        nxt_crc      = crc8_byte(nxt_crc, lockstep_status_byte);
                        nxt_phase    = sumt_pkg::PH_CHECK;
                    end
                end
                sumt_pkg::PH_CHECK: begin
                    nxt_byte_out = crc_ff;
                    nxt_phase    = sumt_pkg::PH_DONE;
                end
                default: begin
                    nxt_byte_out = `SUMT_BYTE_RST;
                end
            endcase
        end
        if (load_out) begin
            nxt_tx_sr = nxt_byte_out;
        end

        // Stop marks end of message; set wins over read-start clear
        if (urx_stop) begin
            nxt_stop    = 1'b1;
            nxt_msg_len = nxt_arrive_cnt;
            nxt_arrive_cnt = 8'h00;
        end
        if (urx_char_err) begin
            nxt_rx_err = 1'b1;
        end
        // Overrun set after the status-read clear, so the event wins
        if (urx_valid && !rxb_in_ready) begin
            nxt_ovf = 1'b1;
        end

        // drain queue to chain, stalled by transmitter
        txq_out_ready = sending_ff && (send_left_ff != 8'h00) && (!utx_valid_ff || utx_ready);
        if (txq_out_ready && txq_out_valid) begin
            nxt_utx_valid = 1'b1;
            nxt_utx_data  = txq_out_data;
            nxt_send_left = send_left_ff - 8'h1;
        end else if (utx_ready) begin
            nxt_utx_valid = 1'b0;
            // Sending ends only once the chain took the last byte
            if (utx_valid_ff && send_left_ff == 8'h00) begin
                nxt_sending = 1'b0;
            end
        end
    end

    // Register all state; read-only unused second tap not exported
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_ff      <= sumt_pkg::ST_CMD;
            phase_ff      <= sumt_pkg::PH_DONE;
            bit_cnt_ff    <= 3'h0;
            rx_sr_ff      <= 8'h00;
            tx_sr_ff      <= 8'h00;
            miso_ff       <= 1'b0;
            load_left_ff  <= 8'h00;
            q_len_ff      <= 8'h00;
            send_left_ff  <= 8'h00;
            crc_ff        <= `SUMT_CRC_INIT;
            msg_len_ff    <= 8'h00;
            arrive_cnt_ff <= 8'h00;
            rd_left_ff    <= 8'h00;
            stop_ff       <= 1'b0;
            rx_err_ff     <= 1'b0;
            ovf_ff        <= 1'b0;
            sending_ff    <= 1'b0;
            ldovf_ff      <= 1'b0;
            utx_valid_ff  <= 1'b0;
            utx_data_ff   <= 8'h00;
        end else begin
            state_ff      <= nxt_state;
            phase_ff      <= nxt_phase;
            bit_cnt_ff    <= nxt_bit_cnt;
            rx_sr_ff      <= nxt_rx_sr;
            tx_sr_ff      <= nxt_tx_sr;
            miso_ff       <= nxt_miso;
            load_left_ff  <= nxt_load_left;
            q_len_ff      <= nxt_q_len;
            send_left_ff  <= nxt_send_left;
            crc_ff        <= nxt_crc;
            msg_len_ff    <= nxt_msg_len;
            arrive_cnt_ff <= nxt_arrive_cnt;
            rd_left_ff    <= nxt_rd_left;
            stop_ff       <= nxt_stop;
            rx_err_ff     <= nxt_rx_err;
            ovf_ff        <= nxt_ovf;
            sending_ff    <= nxt_sending;
            ldovf_ff      <= nxt_ldovf;
            utx_valid_ff  <= nxt_utx_valid;
            utx_data_ff   <= nxt_utx_data;
        end
    end

    // Outputs straight from flops
    assign spi_miso      = miso_ff;
    assign utx_valid     = utx_valid_ff;
    assign utx_data      = utx_data_ff;
    assign load_overflow = ldovf_ff;
    assign sending       = sending_ff;

endmodule : sumt_bridge

`default_nettype wire

// file: bench/sumt_bridge_monitor.sv
/*
 * Checker of the bridge's chain stream, status and SPI answer timing.
 * Assumes binding to every sumt_bridge; sees only its ports.
 */
`timescale 1ns/10ps
`default_nettype none

module sumt_bridge_monitor (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       reset,
    // SPI pins
    input wire logic       spi_sclk,
    input wire logic       spi_cs_n,
    input wire logic       spi_miso,
    // Chain stream and status
    input wire logic       utx_valid,
    input wire logic [7:0] utx_data,
    input wire logic       utx_ready,
    input wire logic       load_overflow,
    input wire logic       sending
);
    logic       sclk_ff;
    logic [3:0] age_ff;
    logic [3:0] nxt_age;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // Cycles since the SPI clock pin fell, saturating
    always_comb begin
        nxt_age = (sclk_ff && !spi_sclk) ? 4'h0 : age_ff + {3'h0, age_ff != 4'hf};
        if (reset) nxt_age = 4'hf;
    end
    always_ff @(posedge ref_clk) begin
        sclk_ff <= spi_sclk;
        age_ff  <= nxt_age;
    end

    // Launch, then first byte offered one cycle later
    sequence s_launch;
        $rose(sending) ##1 utx_valid;
    endsequence
    property p_reset_quiet;
        $fell(reset) |-> !utx_valid && !sending && !load_overflow && !spi_miso;
    endproperty
    property p_hold;
        utx_valid && !utx_ready |=> utx_valid && $stable(utx_data);
    endproperty
    property p_valid_in_send;
        utx_valid |-> sending;
    endproperty
    property p_launch;
        $rose(sending) |-> s_launch;
    endproperty
    property p_launch_cause;
        $rose(sending) |-> !spi_cs_n && !$past(spi_cs_n, 4);
    endproperty
    property p_last_take;
        $fell(sending) |-> $past(utx_valid) && $past(utx_ready);
    endproperty
    property p_ovf_sticky;
        load_overflow |=> load_overflow;
    endproperty
    property p_ovf_cause;
        $rose(load_overflow) |-> !spi_cs_n && !$past(spi_cs_n, 4);
    endproperty
    // Answer bits move only shortly after a falling SPI clock
    property p_miso_timing;
        !spi_cs_n && $changed(spi_miso) |-> age_ff <= 4'h6;
    endproperty

    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs not idle after reset");
    a_hold: assert property (p_hold)
        else $error("chain byte changed while stalled");
    a_valid_in_send: assert property (p_valid_in_send)
        else $error("chain byte offered while not sending");
    a_launch: assert property (p_launch)
        else $error("no chain byte after launch");
    a_launch_cause: assert property (p_launch_cause)
        else $error("launch outside an SPI frame");
    a_last_take: assert property (p_last_take)
        else $error("sending ended without a taken byte");
    a_ovf_sticky: assert property (p_ovf_sticky)
        else $error("load overflow flag dropped");
    a_ovf_cause: assert property (p_ovf_cause)
        else $error("load overflow outside an SPI frame");
    a_miso_timing: assert property (p_miso_timing)
        else $error("answer bit changed away from a clock fall");
endmodule : sumt_bridge_monitor

bind sumt_bridge sumt_bridge_monitor u_mon (
    .ref_clk(ref_clk), .reset(reset), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_miso(spi_miso), .utx_valid(utx_valid), .utx_data(utx_data),
    .utx_ready(utx_ready), .load_overflow(load_overflow), .sending(sending)
);

`default_nettype wire

// file: bench/sumt_spi_host.sv
/*
 * Host model: SPI master in mode 0 issuing the bridge's commands.
 * Assumes a 125 ns SPI clock, each frame started 1 ns after a reference clock rise.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sumt_map.svh"

module sumt_spi_host (
    // Reference clock, to start frames off its edge
    input  wire logic ref_clk,
    // SPI pins
    output var  logic spi_sclk,
    output var  logic spi_cs_n,
    output var  logic spi_mosi,
    input  wire logic spi_miso
);
    localparam realtime HALF = 62.5;
    logic [7:0] rsp_byte;
    event       rsp_ev;

    // Idle: clock low and still, deselected
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    // One byte, MSB first, sampled on the rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_mosi = tx[i];
            #(HALF);
            spi_sclk = 1'b1;
            rx[i] = spi_miso;
            #(HALF);
            spi_sclk = 1'b0;
        end
    endtask : xfer

    task automatic frame(input logic [7:0] cmd);
        logic [7:0] rx;
        @(posedge ref_clk);
        #1;
        spi_cs_n = 1'b0;
        #(HALF);
        xfer(cmd, rx);
    endtask : frame

    // Released data line shows no stale bit
    task automatic close;
        #(HALF);
        spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
        #(4 * HALF);
    endtask : close

    task automatic load(input logic [7:0] msg[$]);
        logic [7:0] rx;
        frame(`SUMT_CMD_LOAD_QUEUE);
        xfer(8'(msg.size()), rx);
        foreach (msg[i]) xfer(msg[i], rx);
        close();
    endtask : load

    task automatic launch;
        frame(`SUMT_CMD_NEXT_QUEUE);
        close();
    endtask : launch

    task automatic read(input logic [7:0] cmd, input int n);
        frame(cmd);
        repeat (n) begin
            xfer(8'hff, rsp_byte);
            -> rsp_ev;
        end
        close();
    endtask : read
endmodule : sumt_spi_host

`default_nettype wire

// file: bench/tb_top.sv
/*
 * Testbench of the bridge: queue load and launch, status and message reads.
 * Assumes the host model and the monitor compiled beside it.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sumt_map.svh"

module tb_top;
    localparam logic [7:0] CRC_POLY = `SUMT_CRC_POLY;
    logic        ref_clk, reset, spi_sclk, spi_cs_n, spi_mosi, spi_miso;
    logic        utx_valid, utx_ready, urx_valid, urx_stop, urx_char_err;
    logic        load_overflow, sending;
    logic [7:0]  utx_data, urx_data, lockstep_status_byte;
    logic [31:0] lfsr = 32'h75af;
    logic [7:0]  exp_tx[$], exp_rx[$], msg[$];
    int          fails = 0;
    int          samples_checked = 0;

    sumt_bridge #(.DEPTH(16), .AW(4), .CRC_POLY(CRC_POLY)) DUT (
        .ref_clk(ref_clk), .reset(reset), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .utx_valid(utx_valid),
        .utx_data(utx_data), .utx_ready(utx_ready), .urx_valid(urx_valid),
        .urx_data(urx_data), .urx_stop(urx_stop), .urx_char_err(urx_char_err),
        .lockstep_status_byte(lockstep_status_byte), .load_overflow(load_overflow),
        .sending(sending));
    sumt_spi_host host (.ref_clk(ref_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso));

    function automatic logic [31:0] rnd(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : rnd
    // Check byte: MSB first, zero start, no reflection
    function automatic logic [7:0] crc8(input logic [7:0] q[$]);
        logic [7:0] c = 8'h00;
        foreach (q[i]) begin
            c = c ^ q[i];
            repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ CRC_POLY : {c[6:0], 1'b0};
        end
        return c;
    endfunction : crc8

    task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (e !== g) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : check

    // Leftover expectations count as misses
    task automatic end_of_test;
        fails = fails + exp_tx.size() + exp_rx.size();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    // One chain byte or error pulse; stale data inverted
    task automatic rx_put(input logic v, input logic [7:0] b, input logic st, input logic er);
        @(posedge ref_clk);
        #1;
        {urx_valid, urx_data, urx_stop, urx_char_err} = {v, b, st, er};
        @(posedge ref_clk);
        #1;
        {urx_valid, urx_data, urx_stop, urx_char_err} = {1'b0, ~b, 2'b00};
    endtask : rx_put

    task automatic wait_idle;
        int n = 0;
        while ((sending !== 1'b0 || exp_tx.size() != 0) && n < 4000) begin
            @(posedge ref_clk);
            n++;
        end
        check("sending", 8'h00, {7'h0, sending});
    endtask : wait_idle

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // Chain stalls at random; taken bytes compared in order
    always @(posedge ref_clk) begin
        lfsr <= rnd(lfsr);
        utx_ready <= #1 lfsr[3] | lfsr[7];
        if (utx_valid === 1'b1 && utx_ready === 1'b1)
            check("utx_data", exp_tx.size() ? exp_tx.pop_front() : ~utx_data, utx_data);
    end
    always @(host.rsp_ev)
        check("answer", exp_rx.size() ? exp_rx.pop_front() : ~host.rsp_byte, host.rsp_byte);
    // Hang guard, well past the expected run
    initial begin
        #200us;
        fails++;
        end_of_test();
    end

    initial begin
        logic [31:0] s;
        {reset, urx_valid, urx_stop, urx_char_err} = 4'h8;
        urx_data = 8'h00;
        lockstep_status_byte = 8'h84;
        repeat (4) @(posedge ref_clk);
        #1 reset = 1'b0;
        repeat (8) @(posedge ref_clk);
        // command, data low first, check, seed
        msg = '{8'h02, 8'h64, 8'hff, 8'h7f, 8'h24, 8'h00};
        exp_tx = msg;
        host.load(msg);
        host.launch();
        wait_idle();
        host.launch();
        check("sending", 8'h00, {7'h0, sending});
        exp_rx = '{8'h00};
        host.read(`SUMT_CMD_READ_STATUS, 1);
        // two devices add two to the seed
        msg = '{8'h02, 8'h64, 8'hff, 8'h7f, 8'h00 + 8'h02};
        foreach (msg[i]) rx_put(1'b1, msg[i], i == msg.size() - 1, 1'b0);
        exp_rx = '{8'h02};
        host.read(`SUMT_CMD_READ_STATUS, 1);
        // echo, lockstep byte, own check byte, then zero
        msg.push_back(8'h84);
        msg.push_back(crc8(msg));
        msg.push_back(8'h00);
        exp_rx = msg;
        host.read(`SUMT_CMD_READ_NEXT_MSG, 8);
        exp_rx = '{8'h00};
        host.read(`SUMT_CMD_READ_STATUS, 1);
        // Queue filled past its 16 bytes, drained under stalls
        msg = {};
        s = lfsr;
        repeat (17) begin
            s = rnd(s);
            msg.push_back(s[15:8]);
        end
        exp_tx = msg[0:15];
        host.load(msg);
        check("load_overflow", 8'h01, {7'h0, load_overflow});
        host.launch();
        wait_idle();
        // Character error, then receive buffer overrun
        rx_put(1'b0, 8'h00, 1'b0, 1'b1);
        exp_rx = '{8'h04, 8'h00};
        repeat (2) host.read(`SUMT_CMD_READ_STATUS, 1);
        repeat (17) begin
            s = rnd(s);
            rx_put(1'b1, s[7:0], 1'b0, 1'b0);
        end
        exp_rx = '{8'h08, 8'h00};
        repeat (2) host.read(`SUMT_CMD_READ_STATUS, 1);
        end_of_test();
    end
endmodule : tb_top

`default_nettype wire
